// file: design/ppcs_params.svh
// Constants for the primary pin and clock status registers
// Assumes inclusion by bare name from design files
`ifndef PPCS_PARAMS_SVH
`define PPCS_PARAMS_SVH

// Register indices on the serial register space
`define PPCS_ADDR_PIN_LEVELS   5'h0A
`define PPCS_ADDR_CLOCK_CHECK  5'h0B
`define PPCS_ADDR_W            5
// Common field positions
`define PPCS_BIT_PARITY        0
`define PPCS_BIT_DISCARD       1
// Pin status word field positions
`define PPCS_BIT_PWM           2
`define PPCS_BIT_INV_PWM       3
`define PPCS_BIT_ALLOW         4
`define PPCS_BIT_FAULT_A       5
`define PPCS_BIT_FAULT_B       6
`define PPCS_BIT_SER_OUT       7
`define PPCS_BIT_DIO           8
// Clock check word count field
`define PPCS_COUNT_LSB         8
`define PPCS_COUNT_W           8
// Values
`define PPCS_SEL_CLOCK         2'h2
`define PPCS_COUNT_RESET       8'h00
`define PPCS_WORD_ZERO         16'h0000
`define PPCS_PINS_RESET        7'h00

`endif

// file: design/ppcs_pkg.sv
// Types for the primary pin and clock status registers
// Assumes the params header sits beside it
package ppcs_pkg;
  // Word returned to the host
  typedef logic [15:0] ppcs_word_type;
  // Verification function selection codes
  typedef enum logic [1:0]
  {
    PPCS_SEL_NONE  = 2'b00,
    PPCS_SEL_RSVD  = 2'b01,
    PPCS_SEL_CLOCK = 2'b10,
    PPCS_SEL_DIO   = 2'b11
  } ppcs_sel_type;
endpackage

// file: design/ppcs_word_fmt.sv
// Finishes a register word: discard flag and odd parity bit
// Overwrites bits 1 and 0 of the body, whatever the caller puts there
`timescale 1ns/10ps
`include "ppcs_params.svh"
module ppcs_word_fmt
  import ppcs_pkg::*;
(
  input  wire ppcs_word_type body_i,
  input  wire logic          discard_i,
  output      ppcs_word_type word_o
);
  // ***************************************************
  // Odd parity over the whole word
  // ***************************************************
  ppcs_word_type with_flag;
  always_comb
  begin
    with_flag = body_i;
    with_flag[`PPCS_BIT_DISCARD] = discard_i;
    with_flag[`PPCS_BIT_PARITY] = 1'b0;
  end
  // Parity bit makes the count of ones odd
  assign word_o = {with_flag[15:1], ~(^with_flag[15:1])};
endmodule // ppcs_word_fmt

// file: design/ppcs_status_regs.sv
// Primary pin level and clock check status registers
// Assumes a frame decoder supplies read address, write strobe and discard flag
`timescale 1ns/10ps
`include "ppcs_params.svh"
// Contract
// - Bit 8 shows digital I/O pin level
// - Bit 7 shows serial output level
// - Bit 6 shows fault B pin level
// - Bit 5 shows fault A pin level
// - Bit 4 shows drive allow pin level
// - Bit 3 shows inverted PWM pin level
// - Bit 2 shows PWM pin level
// - Bit 1 flags previous frame discarded
// - Bit 0 gives odd word parity
// - Count field holds measured oscillator cycles
// - Clear bit zeroes measured count; a new result loaded in the same cycle wins over the clear
// - Measurement only in verification mode, code 10
module ppcs_status_regs
  import ppcs_pkg::*;
#(
  parameter int COUNT_W = `PPCS_COUNT_W
)
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   dio_pin_i,
  input  wire logic                   serial_out_pin_i,
  input  wire logic                   fault_b_pin_i,
  input  wire logic                   fault_a_pin_i,
  input  wire logic                   drive_allow_pin_i,
  input  wire logic                   inverted_pwm_pin_i,
  input  wire logic                   pwm_pin_i,
  input  wire logic [1:0]             verify_function_select_i,
  input  wire logic                   verification_mode_i,
  input  wire logic                   count_valid_i,
  input  wire logic [COUNT_W-1:0]     osc_cycle_count_i,
  input  wire logic                   count_clear_bit_i,
  input  wire logic                   last_frame_discarded_i,
  input  wire logic                   rd_en_i,
  input  wire logic [`PPCS_ADDR_W-1:0] rd_addr_i,
  input  wire logic                   wr_en_i,
  output      logic [15:0]            rd_data_o,
  output      logic                   rd_hit_o,
  output      logic                   measure_active_o
);
  // ***************************************************
  // Parameter check
  // ***************************************************
  generate
    if (COUNT_W != `PPCS_COUNT_W)
    begin : g_bad_width
      $error("Count field must be eight bits wide");
    end
  endgenerate

  // ***************************************************
  // Address decode helper
  // ***************************************************
  function automatic logic is_mapped(input logic [`PPCS_ADDR_W-1:0] a);
    is_mapped = (a == `PPCS_ADDR_PIN_LEVELS) || (a == `PPCS_ADDR_CLOCK_CHECK);
  endfunction

  // ***************************************************
  // Sampled pin levels
  // ***************************************************
  logic [6:0] pins_reg;
  // Levels captured every clock, bit order matches word bits 8..2
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pins_reg <= `PPCS_PINS_RESET;
    else
      pins_reg <= {dio_pin_i,
                   serial_out_pin_i,
                   fault_b_pin_i,
                   fault_a_pin_i,
                   drive_allow_pin_i,
                   inverted_pwm_pin_i,
                   pwm_pin_i};
  end

  // ***************************************************
  // Clock supervision count
  // ***************************************************
  logic               active_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               active_next;
  // Supervision enabled only by selection code plus mode
  assign active_next = verification_mode_i &&
                       (verify_function_select_i == `PPCS_SEL_CLOCK);
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      active_reg <= 1'b0;
    else
      active_reg <= active_next;
  end
  assign measure_active_o = active_reg;
  // New result wins over clear in the same cycle
  always_comb
  begin
    count_next = count_reg;
    if (count_clear_bit_i)
      count_next = `PPCS_COUNT_RESET;
    if (count_valid_i && active_reg)
      count_next = osc_cycle_count_i;
  end
  // Host writes never reach this state
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count_reg <= `PPCS_COUNT_RESET;
    else
      count_reg <= count_next;
  end

  // ***************************************************
  // Word bodies and formatting
  // ***************************************************
  ppcs_word_type pin_body;
  ppcs_word_type clk_body;
  ppcs_word_type pin_word;
  ppcs_word_type clk_word;
  // Reserved bits held at zero
  always_comb
  begin
    pin_body = `PPCS_WORD_ZERO;
    pin_body[`PPCS_BIT_DIO:`PPCS_BIT_PWM] = pins_reg;
    clk_body = `PPCS_WORD_ZERO;
    clk_body[`PPCS_COUNT_LSB +: `PPCS_COUNT_W] = count_reg;
  end
  ppcs_word_fmt u_fmt_pin
  (
    .body_i    (pin_body),
    .discard_i (last_frame_discarded_i),
    .word_o    (pin_word)
  );
  ppcs_word_fmt u_fmt_clk
  (
    .body_i    (clk_body),
    .discard_i (last_frame_discarded_i),
    .word_o    (clk_word)
  );

  // ***************************************************
  // Read port
  // ***************************************************
  // Registered read; writes ignored, unmapped reads give zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= `PPCS_WORD_ZERO;
      rd_hit_o  <= 1'b0;
    end
    else if (rd_en_i && !wr_en_i)
    begin
      rd_hit_o <= is_mapped(rd_addr_i);
      case (rd_addr_i)
        `PPCS_ADDR_PIN_LEVELS:  rd_data_o <= pin_word;
        `PPCS_ADDR_CLOCK_CHECK: rd_data_o <= clk_word;
        default:                rd_data_o <= `PPCS_WORD_ZERO;
      endcase
    end
    else
      rd_hit_o <= 1'b0;
  end
endmodule // ppcs_status_regs

// file: testbench/ppcs_properties.sv
// Checker bound to the status registers
// Sees only the top module ports
`timescale 1ns/10ps
module ppcs_properties
  import ppcs_pkg::*;
#(parameter int COUNT_W = 8)
(
  input wire logic sys_clk_i, rst_b_i, dio_pin_i, serial_out_pin_i, fault_b_pin_i, fault_a_pin_i,
  input wire logic drive_allow_pin_i, inverted_pwm_pin_i, pwm_pin_i, verification_mode_i,
  input wire logic count_valid_i, count_clear_bit_i, last_frame_discarded_i, rd_en_i, wr_en_i,
  input wire logic rd_hit_o, measure_active_o,
  input wire logic [1:0] verify_function_select_i,
  input wire logic [COUNT_W-1:0] osc_cycle_count_i,
  input wire logic [4:0] rd_addr_i,
  input wire logic [15:0] rd_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Request and input shorthands
  wire logic ra = rd_en_i && !wr_en_i && rd_addr_i == 5'h0A;
  wire logic rb = rd_en_i && !wr_en_i && rd_addr_i == 5'h0B;
  wire logic sel = verification_mode_i && verify_function_select_i == PPCS_SEL_CLOCK;
  wire logic idle = !count_valid_i && !count_clear_bit_i;
  wire logic [6:0] pins = {dio_pin_i, serial_out_pin_i, fault_b_pin_i, fault_a_pin_i, drive_allow_pin_i,
    inverted_pwm_pin_i, pwm_pin_i};
  AST_PINS:
    assert property (ra |=> rd_data_o[8:2] == $past(pins, 2)) else $error("pin bits");
  AST_RSVD: assert property ((ra |=> !rd_data_o[15:9]) and (rb |=> !rd_data_o[7:2]))
    else $error("reserved bits");
  AST_PARITY: assert property (ra || rb |=> rd_hit_o && ^rd_data_o)
    else $error("parity");
  AST_DISCARD: assert property (ra || rb |=> rd_data_o[1] == $past(last_frame_discarded_i))
    else $error("discard bit");
  AST_REFUSE: assert property (wr_en_i || rd_en_i && !ra && !rb |=> !rd_hit_o)
    else $error("refused hit");
  AST_MEASURE: assert property (1'b1 |=> measure_active_o == $past(sel))
    else $error("measure enable");
  AST_LOAD: assert property (count_valid_i && measure_active_o ##1 idle ##1 rb
    |=> rd_data_o[15:8] == $past(osc_cycle_count_i, 3)) else $error("count load");
  AST_CLEAR: assert property (count_clear_bit_i && !count_valid_i ##1 idle ##1 rb
    |=> !rd_data_o[15:8]) else $error("count clear");
  cover property (ra);
  cover property (count_valid_i && measure_active_o);
  cover property (count_clear_bit_i);
endmodule // ppcs_properties

bind ppcs_status_regs ppcs_properties #(.COUNT_W(COUNT_W)) i_ppcs_properties (.*);

// file: testbench/ppcs_host_model.sv
// Host model: one register request at a time
// Assumes calls come from the bench main process
`timescale 1ns/10ps
module ppcs_host_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rd_data_o,
  input  wire logic        rd_hit_o,
  output logic             rd_en_i = 1'b0,
  output logic             wr_en_i = 1'b0,
  output logic [4:0]       rd_addr_i = 5'h00
);
  // Request held over the taking edge, released bus shows inverse
  task automatic xfer(input logic [4:0] a, input logic w, output logic [15:0] d, output logic h);
    @(negedge sys_clk_i);
    {rd_en_i, wr_en_i, rd_addr_i} = {1'b1, w, a};
    @(negedge sys_clk_i);
    {rd_en_i, wr_en_i, rd_addr_i} = {2'b00, ~a};
    {d, h} = {rd_data_o, rd_hit_o};
  endtask
endmodule // ppcs_host_model

// file: testbench/ppcs_status_regs_bench.sv
// Bench for pin levels, discard flag and count field
// Assumes the host model issues all register requests
`timescale 1ns/10ps
module ppcs_status_regs_bench;
  import ppcs_pkg::*;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, count_valid_i = 1'b0, last_frame_discarded_i = 1'b0;
  logic verification_mode_i = 1'b0, count_clear_bit_i = 1'b0;
  logic [1:0] verify_function_select_i = 2'h0;
  logic [6:0] pins = 7'h00;
  logic [7:0] osc_cycle_count_i = 8'h00;
  wire logic dio_pin_i, serial_out_pin_i, fault_b_pin_i, fault_a_pin_i, drive_allow_pin_i, inverted_pwm_pin_i;
  wire logic pwm_pin_i, rd_en_i, wr_en_i, rd_hit_o, measure_active_o;
  wire logic [4:0] rd_addr_i;
  wire logic [15:0] rd_data_o;
  int n_fail = 0, total_checks = 0, cycles = 0;
  assign {dio_pin_i, serial_out_pin_i, fault_b_pin_i, fault_a_pin_i, drive_allow_pin_i, inverted_pwm_pin_i,
    pwm_pin_i} = pins;
  ppcs_status_regs i_ppcs_status_regs (.*);
  ppcs_host_model i_ppcs_host_model (.*);
  initial forever #25 sys_clk_i = ~sys_clk_i;
  // Hang guard
  always @(posedge sys_clk_i)
    if (++cycles > 2000)
    begin
      n_fail++;
      give_verdict();
    end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request; a hit word gets odd parity in bit 0
  task automatic rc(input logic [4:0] a, input logic w, input logic [15:0] b, input logic hit);
    logic [15:0] d;
    logic h;
    i_ppcs_host_model.xfer(a, w, d, h);
    chk("word", d, hit ? {b[15:1], ~^b[15:1]} : b);
    chk("hit", {15'h0000, h}, {15'h0000, hit});
  endtask
  // Select a function, then strobe one measured count
  task automatic meas(input logic m, input logic [1:0] s, input logic [7:0] v);
    @(negedge sys_clk_i);
    {verification_mode_i, verify_function_select_i} = {m, s};
    repeat (2) @(negedge sys_clk_i);
    chk("active", {15'h0000, measure_active_o}, {15'h0000, m && (s == 2'h2)});
    {count_valid_i, osc_cycle_count_i} = {1'b1, v};
    @(negedge sys_clk_i);
    count_valid_i = 1'b0;
  endtask
  task automatic t_pins();
    for (int i = 0; i < 8; i++)
    begin
      pins = 7'h40 >> i;
      rc(5'h0A, 1'b0, {7'h00, pins, 2'b00}, 1'b1);
    end
  endtask
  task automatic t_discard();
    last_frame_discarded_i = 1'b1;
    rc(5'h0A, 1'b0, 16'h0002, 1'b1);
    rc(5'h0B, 1'b0, 16'h0002, 1'b1);
    last_frame_discarded_i = 1'b0;
  endtask
  task automatic t_count();
    logic [7:0] e;
    e = 8'hA5;
    meas(1'b1, PPCS_SEL_CLOCK, e);
    rc(5'h0B, 1'b0, {e, 8'h00}, 1'b1);
    for (int s = 0; s < 5; s++)
    begin
      meas(s < 4, (s < 4) ? s[1:0] : 2'h2, {5'h02, s[2:0]});
      if (s == 2)
        e = 8'h12;
      rc(5'h0B, 1'b0, {e, 8'h00}, 1'b1);
    end
    @(negedge sys_clk_i);
    count_clear_bit_i = 1'b1;
    @(negedge sys_clk_i);
    count_clear_bit_i = 1'b0;
    rc(5'h0B, 1'b0, 16'h0000, 1'b1);
    rc(5'h0B, 1'b1, 16'h0001, 1'b0);
    rc(5'h0C, 1'b0, 16'h0000, 1'b0);
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    rc(5'h0B, 1'b0, 16'h0000, 1'b1);
    t_pins();
    t_discard();
    t_count();
    give_verdict();
  end
endmodule // ppcs_status_regs_bench
